// ### bench/tif_host_model.sv
/* host side of the interrupt pin: a pull-up on the wire;
   assumes oe high means the block drives the pin. */
`timescale 1ns/1ps
module tif_host_model (
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe,
  output logic irq_level
);
  // open drain only ever pulls low, the resistor makes the high level
  assign irq_level = irq_pin_oe ? irq_pin_out : 1'b1;
endmodule : tif_host_model

// ### bench/tif_irq_flags_bench.sv
/* self-checking bench for the interrupt flag block;
   assumes the host model pulls the released pin up. */
`timescale 1ns/1ps
module tif_irq_flags_bench;
  import tif_pkg::*;
  logic mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, tx_last_bit_sent = 0, rx_end_valid = 0;
  logic ignore_empty_receive = 0, rx_fifo_has_data = 0, cmd_self_finish = 0, cmd_start = 0;
  logic fifo_full_warning_live = 0, fifo_empty_warning_live = 0, timer_zero = 0;
  logic secure_link_input = 0, auto_anticollision_cmd = 0, mode_found = 0, rf_reset = 0;
  logic crc_cmd_active = 0, crc_all_processed = 0, field_detect = 0, irq_level;
  logic cmd_force_idle, mode_detect_run, irq_status, irq_pin_out, irq_pin_oe;
  logic [3:0] cmd_start_code = 4'h0;
  tif_addr_t reg_addr = '0;
  tif_data_t reg_wdata = '0, reg_rdata, error_status = '0;
  tif_data_t evx [11] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h10, 8'h04,
    8'h02, 8'h01};
  int errors = 0, tests_run = 0;
  always #5 mclk = ~mclk;
  // only idle is known, so every other code counts as unknown
  tif_irq_flags #(.KNOWN_CMD_MASK(16'h0001)) i_dut (.mclk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .tx_last_bit_sent, .rx_end_valid, .ignore_empty_receive,
    .rx_fifo_has_data, .cmd_self_finish, .cmd_start, .cmd_start_code, .cmd_force_idle,
    .fifo_full_warning_live, .fifo_empty_warning_live, .error_status, .timer_zero,
    .secure_link_input, .auto_anticollision_cmd, .mode_found, .rf_reset, .mode_detect_run,
    .crc_cmd_active, .crc_all_processed, .field_detect, .irq_status, .irq_pin_out,
    .irq_pin_oe);
  tif_host_model i_host (.irq_pin_out, .irq_pin_oe, .irq_level);
  task automatic end_sim();
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input tif_data_t got, input tif_data_t exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask : chk
  task automatic wr(input tif_addr_t a, input tif_data_t d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input tif_addr_t a, input tif_data_t exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic fire(input int k);
    @(posedge mclk);
    case (k)
      0: tx_last_bit_sent <= 1'b1;
      1: rx_end_valid <= 1'b1;
      2: cmd_self_finish <= 1'b1;
      3: fifo_full_warning_live <= 1'b1;
      4: fifo_empty_warning_live <= 1'b1;
      5: error_status <= 8'h10;
      6: timer_zero <= 1'b1;
      7: secure_link_input <= ~secure_link_input;
      8: crc_all_processed <= 1'b1;
      9, 10: field_detect <= ~field_detect;
      11: rf_reset <= 1'b1;
      default: mode_found <= 1'b1;
    endcase
    @(posedge mclk);
    {tx_last_bit_sent, rx_end_valid, cmd_self_finish, timer_zero, rf_reset} <= '0;
    {fifo_full_warning_live, fifo_empty_warning_live, crc_all_processed, mode_found} <= '0;
    error_status <= 8'h00;
    // pin inputs cross two sync stages first
    repeat (4) @(posedge mclk);
  endtask : fire
  task automatic t_setclr();
    rd(6'h3F, 8'h00);
    wr(MAIN_FLAG_OFS, 8'hFF);
    rd(MAIN_FLAG_OFS, 8'h7F);
    wr(MAIN_FLAG_OFS, 8'h05);
    rd(MAIN_FLAG_OFS, 8'h7A);
    wr(AUX_FLAG_OFS, 8'hFF);
    rd(AUX_FLAG_OFS, 8'h1F);
    wr(AUX_FLAG_OFS, 8'h01);
    rd(AUX_FLAG_OFS, 8'h1E);
    wr(AUX_EN_OFS, 8'hFF);
    rd(AUX_EN_OFS, 8'h9F);
    wr(AUX_EN_OFS, 8'h00);
    wr(MAIN_FLAG_OFS, 8'h7F);
    wr(AUX_FLAG_OFS, 8'h1F);
    $display("t_setclr done");
  endtask : t_setclr
  task automatic t_events();
    tif_addr_t a;
    crc_cmd_active <= 1'b1;
    for (int k = 0; k < 11; k++)
    begin
      a = (k < 7) ? MAIN_FLAG_OFS : AUX_FLAG_OFS;
      fire(k);
      rd(a, evx[k]);
      rd(a, evx[k]);
      wr(a, evx[k]);
      rd(a, 8'h00);
    end
    crc_cmd_active <= 1'b0;
    $display("t_events done");
  endtask : t_events
  task automatic t_rx_mode();
    ignore_empty_receive <= 1'b1;
    auto_anticollision_cmd <= 1'b1;
    fire(1);
    rd(MAIN_FLAG_OFS, 8'h00);
    rx_fifo_has_data <= 1'b1;
    fire(1);
    rd(MAIN_FLAG_OFS, 8'h20);
    fire(12);
    rd(AUX_FLAG_OFS, 8'h08);
    wr(AUX_FLAG_OFS, 8'h08);
    fire(12);
    rd(AUX_FLAG_OFS, 8'h00);
    fire(11);
    fire(12);
    rd(AUX_FLAG_OFS, 8'h08);
    wr(AUX_FLAG_OFS, 8'h08);
    wr(MAIN_FLAG_OFS, 8'h20);
    auto_anticollision_cmd <= 1'b0;
    $display("t_rx_mode done");
  endtask : t_rx_mode
  task automatic t_cmd();
    for (int c = 5; c >= 0; c -= 5)
    begin
      @(posedge mclk);
      cmd_start <= 1'b1;
      cmd_start_code <= 4'(c);
      @(posedge mclk);
      cmd_start <= 1'b0;
      #1 chk({7'h00, cmd_force_idle}, (c > 0) ? 8'h01 : 8'h00);
      rd(MAIN_FLAG_OFS, (c > 0) ? 8'h10 : 8'h00);
      wr(MAIN_FLAG_OFS, 8'h10);
    end
    $display("t_cmd done");
  endtask : t_cmd
  task automatic pin(input tif_data_t me, input tif_data_t ae, input logic l, input logic oe);
    wr(MAIN_EN_OFS, me);
    wr(AUX_EN_OFS, ae);
    repeat (2) @(posedge mclk);
    #1 chk({7'h00, irq_level}, {7'h00, l});
    chk({7'h00, irq_pin_oe}, {7'h00, oe});
    chk({7'h00, irq_status}, {7'h00, l ^ me[INVERT_BIT]});
  endtask : pin
  task automatic t_pin();
    wr(MAIN_FLAG_OFS, 8'h81);
    pin(8'h01, 8'h80, 1'b1, 1'b1);
    pin(8'h81, 8'h80, 1'b0, 1'b1);
    pin(8'h00, 8'h80, 1'b0, 1'b1);
    pin(8'h80, 8'h00, 1'b1, 1'b0);
    pin(8'h81, 8'h00, 1'b0, 1'b1);
    wr(MAIN_FLAG_OFS, 8'h01);
    wr(AUX_FLAG_OFS, 8'h82);
    pin(8'h00, 8'h82, 1'b1, 1'b1);
    pin(8'h00, 8'h80, 1'b0, 1'b1);
    $display("t_pin done");
  endtask : t_pin
  initial
  begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    rd(MAIN_EN_OFS, MAIN_EN_RST);
    rd(AUX_EN_OFS, 8'h00);
    rd(MAIN_FLAG_OFS, 8'h14);
    t_setclr();
    t_events();
    t_rx_mode();
    t_cmd();
    t_pin();
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_sim();
  end
endmodule : tif_irq_flags_bench

// ### bench/tif_irq_flags_monitor.sv
/* assertions on the ports of the interrupt flag block;
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module tif_irq_monitor
  import tif_pkg::*;
#(
  parameter logic [15:0] KNOWN_CMD_MASK = 16'hFFFF
) (
  input wire logic mclk,
  input wire logic reset,
  input wire tif_pkg::tif_addr_t reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cmd_start,
  input wire logic [3:0] cmd_start_code,
  input wire logic cmd_force_idle,
  input wire logic auto_anticollision_cmd,
  input wire logic mode_found,
  input wire logic rf_reset,
  input wire logic mode_detect_run,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // rf reset wins over a found in the same cycle, yet that case is left out
  sequence rearm_s;
    rf_reset && auto_anticollision_cmd && !mode_found ##1 auto_anticollision_cmd;
  endsequence
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  flag_top_a: assert property (reg_rd && (reg_addr == MAIN_FLAG_OFS ||
    reg_addr == AUX_FLAG_OFS) |=> !reg_rdata[7]) else $error("flag bit 7 read back");
  aux_reserved_a: assert property (reg_rd && (reg_addr == AUX_EN_OFS ||
    reg_addr == AUX_FLAG_OFS) |=> reg_rdata[6:5] == 2'b00) else $error("reserved bits set");
  drive_style_a: assert property (irq_pin_out |-> irq_pin_oe)
    else $error("pin high while not driven");
  unknown_cmd_a: assert property (cmd_start && !KNOWN_CMD_MASK[cmd_start_code]
    |=> cmd_force_idle) else $error("unknown command kept");
  idle_cmd_a: assert property (cmd_start && cmd_start_code == IDLE_CMD
    |=> !cmd_force_idle) else $error("idle start forced idle");
  mode_gate_a: assert property (!auto_anticollision_cmd |-> !mode_detect_run)
    else $error("detector outside anticollision");
  mode_stop_a: assert property (mode_found && mode_detect_run && !rf_reset
    |=> !mode_detect_run) else $error("detector kept running");
  mode_rearm_a: assert property (rearm_s |-> mode_detect_run)
    else $error("detector not restarted");
  reset_open_a: assert property ($fell(reset) |-> !irq_pin_oe)
    else $error("pin driven after reset");
endmodule : tif_irq_monitor
bind tif_irq_flags tif_irq_monitor #(.KNOWN_CMD_MASK(KNOWN_CMD_MASK)) i_mon (.mclk, .reset,
  .reg_addr, .reg_rd, .reg_rdata, .cmd_start, .cmd_start_code, .cmd_force_idle,
  .auto_anticollision_cmd, .mode_found, .rf_reset, .mode_detect_run, .irq_pin_out,
  .irq_pin_oe);

// ### src/tif_irq_flags.sv
/*
  interrupt enable and flag registers of a contactless transceiver,
  with the interrupt pin driver.
  assumes event inputs come from logic on mclk, except the secure
  link input and the field detect level, which are pins.
*/
// Our own choice: the plain strobed port.
// Function
// - drive style bit 1 gives push-pull pin, 0 gives open drain
// - aux enable bits 4..0 gate their aux flags onto the pin
// - main flag write: marked bits set if bit 7 high, else cleared
// - aux flag write: marked bits set if bit 7 high, else cleared
// - transmit done flag sets after the last outgoing bit
// - receive done sets at valid end; with option only if fifo has data
// - command finished flag sets when a command ends on its own
// - unknown command returns to idle and sets flag; host idle does not
// - full warning flag latches when the live warning rises
// - empty warning flag latches when the live warning rises
// - fault flag sets while any error status bit is set
// - countdown zero flag sets when the timer reaches zero
// - input edge flag sets on either edge of secure link input
// - mode flag sets on detection; detector runs only in anticollision
// - mode detector restarts after every rf reset
// - crc done flag sets when crc command has processed all data
// - field on sets when field appears, field off when it vanishes
// - reserved aux bits 6 and 5 read as zero
// - aux enable resets to zero: all off, pin open drain
// - invert bit flips the pin level against the combined status
// - main enable bits gate each main flag onto the pin
`timescale 1ns/1ps
module tif_irq_flags #(
  parameter logic [15:0] KNOWN_CMD_MASK = 16'hFFFF
) (
  input wire logic mclk,
  input wire logic reset,
  input wire tif_pkg::tif_addr_t reg_addr,
  input wire tif_pkg::tif_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tx_last_bit_sent,
  input wire logic rx_end_valid,
  input wire logic ignore_empty_receive,
  input wire logic rx_fifo_has_data,
  input wire logic cmd_self_finish,
  input wire logic cmd_start,
  input wire logic [3:0] cmd_start_code,
  output logic cmd_force_idle,
  input wire logic fifo_full_warning_live,
  input wire logic fifo_empty_warning_live,
  input wire logic [7:0] error_status,
  input wire logic timer_zero,
  input wire logic secure_link_input,
  input wire logic auto_anticollision_cmd,
  input wire logic mode_found,
  input wire logic rf_reset,
  output logic mode_detect_run,
  input wire logic crc_cmd_active,
  input wire logic crc_all_processed,
  input wire logic field_detect,
  output logic irq_status,
  output logic irq_pin_out,
  output logic irq_pin_oe
);
  import tif_pkg::*;

  tif_data_t main_en_ff;
  tif_data_t aux_en_ff;
  tif_data_t main_flags_ff;
  tif_data_t aux_flags_ff;
  tif_data_t nxt_main_flags;
  tif_data_t nxt_aux_flags;
  tif_data_t main_hw_set;
  tif_data_t aux_hw_set;
  tif_data_t rdata_ff;
  logic full_live_ff;
  logic empty_live_ff;
  logic [1:0] sig_sync_ff;
  logic sig_prev_ff;
  logic [1:0] fld_sync_ff;
  logic fld_prev_ff;
  logic auto_anticollision_cmd_prev_ff;
  logic mode_armed_ff;
  logic force_idle_ff;
  logic status_ff;
  logic pin_out_ff;
  logic pin_oe_ff;
  logic nxt_status;
  logic pin_level;
  logic bad_cmd;
  logic main_en_wr;
  logic aux_en_wr;
  logic main_flag_wr;
  logic aux_flag_wr;
  tif_data_t main_gated;
  tif_data_t aux_gated;
  tif_data_t nxt_rdata;
  logic sig_edge;
  logic fld_rise;
  logic fld_fall;
  logic full_rise;
  logic empty_rise;

  // write-one-marked set or clear; hardware set wins over a clear
  function automatic tif_data_t apply_write(
    input tif_data_t cur,
    input tif_data_t wdata,
    input tif_data_t mask,
    input tif_data_t hw_set,
    input logic hit
  );
    tif_data_t marked;
    tif_data_t res;
    marked = wdata & mask;
    res = cur;
    if (hit)
    begin
      if (wdata[SET_CLR_BIT])
        res = cur | marked;
      else
        res = cur & ~marked;
    end
    return (res | hw_set) & mask;
  endfunction : apply_write

  // one decode for every register write strobe; the read mux decodes reg_addr on its own
  function automatic logic addr_hit(
    input tif_addr_t addr,
    input tif_addr_t ofs,
    input logic strobe
  );
    return strobe && (addr == ofs);
  endfunction : addr_hit

  always_comb
  begin
    main_en_wr = addr_hit(reg_addr, MAIN_EN_OFS, reg_wr);
    aux_en_wr = addr_hit(reg_addr, AUX_EN_OFS, reg_wr);
    main_flag_wr = addr_hit(reg_addr, MAIN_FLAG_OFS, reg_wr);
    aux_flag_wr = addr_hit(reg_addr, AUX_FLAG_OFS, reg_wr);
  end

  // idle is excluded by code, so a mask that forgets it cannot fake a finish
  always_comb
  begin
    bad_cmd = cmd_start && (cmd_start_code != IDLE_CMD) &&
      !KNOWN_CMD_MASK[cmd_start_code];
  end

  // edge terms; the live fifo bits come from mclk logic and need no sync
  always_comb
  begin
    full_rise = fifo_full_warning_live && !full_live_ff;
    empty_rise = fifo_empty_warning_live && !empty_live_ff;
    sig_edge = sig_sync_ff[1] ^ sig_prev_ff;
    fld_rise = fld_sync_ff[1] && !fld_prev_ff;
    fld_fall = !fld_sync_ff[1] && fld_prev_ff;
  end

  always_comb
  begin
    main_hw_set = '0;
    main_hw_set[TX_DONE_BIT] = tx_last_bit_sent;
    main_hw_set[RX_DONE_BIT] = rx_end_valid &&
      (!ignore_empty_receive || rx_fifo_has_data);
    // a host start of the idle command reaches neither term
    main_hw_set[CMD_FIN_BIT] = cmd_self_finish || bad_cmd;
    main_hw_set[FULL_WARN_BIT] = full_rise;
    main_hw_set[EMPTY_WARN_BIT] = empty_rise;
    main_hw_set[FAULT_BIT] = |error_status;
    main_hw_set[CNT_ZERO_BIT] = timer_zero;
  end

  always_comb
  begin
    aux_hw_set = '0;
    aux_hw_set[EDGE_BIT] = sig_edge;
    aux_hw_set[MODE_BIT] = mode_found && mode_detect_run;
    aux_hw_set[CRC_BIT] = crc_cmd_active && crc_all_processed;
    aux_hw_set[FIELD_ON_BIT] = fld_rise;
    aux_hw_set[FIELD_OFF_BIT] = fld_fall;
  end

  always_comb
  begin
    nxt_main_flags = apply_write(main_flags_ff, reg_wdata, MAIN_FIELD_MASK,
      main_hw_set, main_flag_wr);
  end

  always_comb
  begin
    nxt_aux_flags = apply_write(aux_flags_ff, reg_wdata, AUX_FIELD_MASK,
      aux_hw_set, aux_flag_wr);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      main_flags_ff <= MAIN_FLAG_RST;
      aux_flags_ff <= AUX_FLAG_RST;
    end
    else
    begin
      main_flags_ff <= nxt_main_flags;
      aux_flags_ff <= nxt_aux_flags;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      main_en_ff <= MAIN_EN_RST;
    else if (main_en_wr)
      main_en_ff <= reg_wdata;
  end

  // reserved bits are dropped on the way in, so they always read zero
  always_ff @(posedge mclk)
  begin
    if (reset)
      aux_en_ff <= AUX_EN_RST;
    else if (aux_en_wr)
      aux_en_ff <= reg_wdata & (AUX_FIELD_MASK | 8'h80);
  end

  // previous live fifo levels for rising edge detection
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      full_live_ff <= 1'b0;
      empty_live_ff <= 1'b0;
    end
    else
    begin
      full_live_ff <= fifo_full_warning_live;
      empty_live_ff <= fifo_empty_warning_live;
    end
  end

  // secure link input is a pin: two flops before the edge compare
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sig_sync_ff <= 2'h0;
      sig_prev_ff <= 1'b0;
    end
    else
    begin
      sig_sync_ff <= {sig_sync_ff[0], secure_link_input};
      sig_prev_ff <= sig_sync_ff[1];
    end
  end

  // field detect is a pin too; its edges cost three cycles of latency
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      fld_sync_ff <= 2'h0;
      fld_prev_ff <= 1'b0;
    end
    else
    begin
      fld_sync_ff <= {fld_sync_ff[0], field_detect};
      fld_prev_ff <= fld_sync_ff[1];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      auto_anticollision_cmd_prev_ff <= 1'b0;
    else
      auto_anticollision_cmd_prev_ff <= auto_anticollision_cmd;
  end

  // detector armed at anticollision start and by rf reset, disarmed once found
  always_ff @(posedge mclk)
  begin
    if (reset)
      mode_armed_ff <= 1'b0;
    else if (rf_reset)
      mode_armed_ff <= 1'b1;
    else if (auto_anticollision_cmd && !auto_anticollision_cmd_prev_ff)
      mode_armed_ff <= 1'b1;
    else if (mode_found && mode_detect_run)
      mode_armed_ff <= 1'b0;
  end

  assign mode_detect_run = mode_armed_ff && auto_anticollision_cmd;

  always_ff @(posedge mclk)
  begin
    if (reset)
      force_idle_ff <= 1'b0;
    else
      force_idle_ff <= bad_cmd;
  end

  always_comb
  begin
    main_gated = nxt_main_flags & main_en_ff & MAIN_FIELD_MASK;
    aux_gated = nxt_aux_flags & aux_en_ff & AUX_FIELD_MASK;
    nxt_status = (|main_gated) || (|aux_gated);
    pin_level = nxt_status ^ main_en_ff[INVERT_BIT];
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      status_ff <= 1'b0;
    else
      status_ff <= nxt_status;
  end

  // open drain only pulls low; a high level is left to the pull-up
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end
    else
    begin
      if (aux_en_ff[DRIVE_BIT])
      begin
        pin_out_ff <= pin_level;
        pin_oe_ff <= 1'b1;
      end
      else
      begin
        pin_out_ff <= 1'b0;
        pin_oe_ff <= !pin_level;
      end
    end
  end

  // the read mux sees the registers, so a same-cycle event shows next read
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        MAIN_EN_OFS: nxt_rdata = main_en_ff;
        AUX_EN_OFS: nxt_rdata = aux_en_ff;
        MAIN_FLAG_OFS: nxt_rdata = main_flags_ff;
        AUX_FLAG_OFS: nxt_rdata = aux_flags_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // read data stands one cycle only and is zero otherwise
  always_ff @(posedge mclk)
  begin
    if (reset)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata = rdata_ff;
  assign cmd_force_idle = force_idle_ff;
  assign irq_status = status_ff;
  assign irq_pin_out = pin_out_ff;
  assign irq_pin_oe = pin_oe_ff;
endmodule : tif_irq_flags

// ### src/tif_pkg.sv
/*
  constants for the transceiver interrupt flag block: register
  offsets, field positions, reset values.
  assumes an 8-bit register port with 6-bit addresses.
*/
package tif_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  typedef logic [ADDR_W-1:0] tif_addr_t;
  typedef logic [DATA_W-1:0] tif_data_t;

  localparam tif_addr_t MAIN_EN_OFS = 6'h02;
  localparam tif_addr_t AUX_EN_OFS = 6'h03;
  localparam tif_addr_t MAIN_FLAG_OFS = 6'h04;
  localparam tif_addr_t AUX_FLAG_OFS = 6'h05;

  localparam tif_data_t MAIN_EN_RST = 8'h80;
  localparam tif_data_t AUX_EN_RST = 8'h00;
  localparam tif_data_t MAIN_FLAG_RST = 8'h14;
  localparam tif_data_t AUX_FLAG_RST = 8'h00;

  // bit 7 of each enable / flag register
  localparam int SET_CLR_BIT = 7;
  localparam int INVERT_BIT = 7;
  localparam int DRIVE_BIT = 7;

  // flag and enable field masks
  localparam tif_data_t MAIN_FIELD_MASK = 8'h7F;
  localparam tif_data_t AUX_FIELD_MASK = 8'h1F;

  // main flag positions
  localparam int TX_DONE_BIT = 6;
  localparam int RX_DONE_BIT = 5;
  localparam int CMD_FIN_BIT = 4;
  localparam int FULL_WARN_BIT = 3;
  localparam int EMPTY_WARN_BIT = 2;
  localparam int FAULT_BIT = 1;
  localparam int CNT_ZERO_BIT = 0;

  // aux flag positions
  localparam int EDGE_BIT = 4;
  localparam int MODE_BIT = 3;
  localparam int CRC_BIT = 2;
  localparam int FIELD_ON_BIT = 1;
  localparam int FIELD_OFF_BIT = 0;

  localparam logic [3:0] IDLE_CMD = 4'h0;
endpackage : tif_pkg
